// File: rtl/config_control_map.vh
// Register offsets, field positions, reset values and timing counts for the configuration control block
`ifndef CONFIG_CONTROL_MAP_VH
`define CONFIG_CONTROL_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CFG_CTRL_OFFSET        4'h0
`define CFG_UNLOCK_OFFSET      4'h4
`define CFG_STATUS_OFFSET      4'h8
`define CFG_ADDR_BITS          4

// ****************************************
// Field positions of the control register
// ****************************************
`define CFG_PIN_LOCK_BIT       13
`define CFG_MOD_LOCK_BIT       12
`define CFG_DBG_EN_BIT         3
`define CFG_TDO_USE_BIT        0
`define CFG_ONES_MASK          32'h0000_0006

// ****************************************
// Reset values
// ****************************************
`define CFG_TDO_USE_RST        1'b1
`define CFG_LOCK_RST           1'b0

// ****************************************
// Unlock keys, written in order to the unlock register
// ****************************************
`define CFG_KEY1               32'haa99_6655
`define CFG_KEY2               32'h5566_99aa

// ****************************************
// Timing: fuse reload then fetch delay
// ****************************************
`define CFG_CLK_MHZ            20
`define CFG_FUSE_RELOAD_US     1
`define CFG_FUSE_CYCLES        (`CFG_FUSE_RELOAD_US * `CFG_CLK_MHZ)
`define CFG_FETCH_DLY_CYCLES   8
`define CFG_CNT_BITS           6

`endif

// File: rtl/boot_delay.v
// Post-reset fuse reload and fetch delay sequencer
`timescale 1ns/1ps
`default_nettype none
`include "config_control_map.vh"

module boot_delay
(
  input  wire       ref_clk,
  input  wire       rst_b,
  output reg        fuse_load,
  output reg        fetch_ok
);

  localparam [1:0] ST_RELOAD = 2'h0;
  localparam [1:0] ST_WAIT   = 2'h1;
  localparam [1:0] ST_DONE   = 2'h2;

  // Counts worked out as integers, then cut to the counter width on purpose
  localparam integer FUSE_N  = `CFG_FUSE_CYCLES - 1;
  localparam integer FETCH_N = `CFG_FETCH_DLY_CYCLES - 1;

  localparam [`CFG_CNT_BITS-1:0] FUSE_LAST  = FUSE_N[`CFG_CNT_BITS-1:0];
  localparam [`CFG_CNT_BITS-1:0] FETCH_LAST = FETCH_N[`CFG_CNT_BITS-1:0];

  reg [1:0]               state_q;
  reg [`CFG_CNT_BITS-1:0] cnt_q;

  // ****************************************
  // Reload fuses, then count fetch cycles
  // ****************************************
  // One pulse of fuse_load at the end of reload lets the owner capture fuses once
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q   <= ST_RELOAD;
      cnt_q     <= {`CFG_CNT_BITS{1'b0}};
      fuse_load <= 1'b0;
      fetch_ok  <= 1'b0;
    end
    else
    begin
      fuse_load <= 1'b0;
      case (state_q)
        ST_RELOAD:
        begin
          if (cnt_q == FUSE_LAST)
          begin
            state_q   <= ST_WAIT;
            cnt_q     <= {`CFG_CNT_BITS{1'b0}};
            fuse_load <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_WAIT:
        begin
          if (cnt_q == FETCH_LAST)
          begin
            state_q  <= ST_DONE;
            fetch_ok <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        ST_DONE:
          fetch_ok <= 1'b1;
        default:
          state_q <= ST_RELOAD;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: rtl/config_control.v
// Configuration control register with lock bits behind an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "config_control_map.vh"

module config_control
(
  input  wire        ref_clk,
  input  wire        rst_b,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Configuration word zero, debug enable fuse (pin, synchronised here)
  input  wire        cfg_word0_dbg_en,
  // Writes headed for protected register groups
  input  wire        pin_select_wr_req,
  input  wire        module_disable_wr_req,
  output reg         pin_select_wr_en,
  output reg         module_disable_wr_en,
  // Control outputs
  output reg         debug_port_enable,
  output reg         two_wire_output_use,
  output reg         pin_select_lock,
  output reg         module_disable_lock,
  output reg         fetch_enable
);

  localparam [1:0] RESP_OKAY   = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  localparam [1:0] UL_IDLE = 2'h0;
  localparam [1:0] UL_KEY1 = 2'h1;
  localparam [1:0] UL_OPEN = 2'h2;

  // ****************************************
  // Fuse pin synchroniser and boot sequencer
  // ****************************************
  reg  fuse_s1_q;
  reg  fuse_s2_q;
  wire fuse_load;
  wire fetch_ok;

  // Two stages; only the second is read
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
    end
    else
    begin
      fuse_s1_q <= cfg_word0_dbg_en;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  boot_delay boot_delay_i
  (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .fuse_load (fuse_load),
    .fetch_ok  (fetch_ok)
  );

  // ****************************************
  // AXI4-Lite write channel capture
  // ****************************************
  reg        aw_held_q;
  reg        w_held_q;
  reg [3:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take  = s_axi_wvalid & s_axi_wready;
  wire       wr_go   = aw_held_q & w_held_q & ~s_axi_bvalid;

  // Address and data taken in either order; held until response issued
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_held_q & ~aw_take & ~wr_go;
      s_axi_wready  <= ~w_held_q & ~w_take & ~wr_go;
      if (aw_take)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_q <= 1'b0;
      if (w_take)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_q <= 1'b0;
    end
  end

  // ****************************************
  // Unlock sequence and control register
  // ****************************************
  reg  [1:0] ul_state_q;
  wire       wr_ctrl   = wr_go & (aw_addr_q == `CFG_CTRL_OFFSET);
  wire       wr_unlock = wr_go & (aw_addr_q == `CFG_UNLOCK_OFFSET);
  wire       wr_status = wr_go & (aw_addr_q == `CFG_STATUS_OFFSET);
  wire       unlocked  = (ul_state_q == UL_OPEN);

  // Two keys in a row open the locks; any other write to unlock closes them.
  // A control write consumes the open window so each lock change needs a fresh key.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      ul_state_q <= UL_IDLE;
    else if (wr_unlock)
    begin
      case (ul_state_q)
        UL_IDLE:  ul_state_q <= (w_data_q == `CFG_KEY1) ? UL_KEY1 : UL_IDLE;
        UL_KEY1:  ul_state_q <= (w_data_q == `CFG_KEY2) ? UL_OPEN : UL_IDLE;
        UL_OPEN:  ul_state_q <= UL_IDLE;
        default:  ul_state_q <= UL_IDLE;
      endcase
    end
    else if (wr_ctrl && unlocked)
      ul_state_q <= UL_IDLE;
  end

  // Control bits; byte lanes honoured
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      debug_port_enable   <= 1'b0;
      two_wire_output_use <= `CFG_TDO_USE_RST;
      pin_select_lock     <= `CFG_LOCK_RST;
      module_disable_lock <= `CFG_LOCK_RST;
    end
    else
    begin
      if (fuse_load)
        debug_port_enable <= fuse_s2_q;
      else if (wr_ctrl && w_strb_q[0])
        debug_port_enable <= w_data_q[`CFG_DBG_EN_BIT];
      if (wr_ctrl && w_strb_q[0])
        two_wire_output_use <= w_data_q[`CFG_TDO_USE_BIT];
      // Locks move only while the unlock window is open
      if (wr_ctrl && w_strb_q[1] && unlocked)
      begin
        pin_select_lock     <= w_data_q[`CFG_PIN_LOCK_BIT];
        module_disable_lock <= w_data_q[`CFG_MOD_LOCK_BIT];
      end
    end
  end

  // ****************************************
  // Write response
  // ****************************************
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_ctrl | wr_unlock | wr_status) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ****************************************
  // Read channel
  // ****************************************
  reg [31:0] rd_word;

  // Unimplemented bits read zero, bits 2..1 of the control word read one
  always @*
  begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `CFG_CTRL_OFFSET:
      begin
        rd_word = `CFG_ONES_MASK;
        rd_word[`CFG_PIN_LOCK_BIT] = pin_select_lock;
        rd_word[`CFG_MOD_LOCK_BIT] = module_disable_lock;
        rd_word[`CFG_DBG_EN_BIT]   = debug_port_enable;
        rd_word[`CFG_TDO_USE_BIT]  = two_wire_output_use;
      end
      `CFG_UNLOCK_OFFSET: rd_word = {31'h0000_0000, unlocked};
      `CFG_STATUS_OFFSET: rd_word = {31'h0000_0000, fetch_ok};
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  wire rd_hit = (s_axi_araddr == `CFG_CTRL_OFFSET) | (s_axi_araddr == `CFG_UNLOCK_OFFSET) |
                (s_axi_araddr == `CFG_STATUS_OFFSET);

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Lock gating for protected write groups
  // ****************************************
  // Registered gate adds a cycle of latency but keeps the outputs clean
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_select_wr_en     <= 1'b0;
      module_disable_wr_en <= 1'b0;
      fetch_enable         <= 1'b0;
    end
    else
    begin
      pin_select_wr_en     <= pin_select_wr_req & ~pin_select_lock;
      module_disable_wr_en <= module_disable_wr_req & ~module_disable_lock;
      fetch_enable         <= fetch_ok;
    end
  end

endmodule
`default_nettype wire

// File: dv/config_control_checker.sv
// Concurrent checks on the configuration control block ports
`timescale 1ns/1ps
`default_nettype none
module config_control_checker
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        cfg_word0_dbg_en,
  input wire logic        pin_select_wr_req,
  input wire logic        module_disable_wr_req,
  input wire logic        pin_select_wr_en,
  input wire logic        module_disable_wr_en,
  input wire logic        debug_port_enable,
  input wire logic        two_wire_output_use,
  input wire logic        pin_select_lock,
  input wire logic        module_disable_lock,
  input wire logic        fetch_enable
);
  logic       rd_ctrl_q;
  logic [5:0] cnt_q;

  // Cycles since reset, and whether the pending read targets the control word
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_q     <= 6'h0;
      rd_ctrl_q <= 1'b0;
    end
    else
    begin
      cnt_q     <= (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h1;
      rd_ctrl_q <= (s_axi_arvalid && s_axi_arready) ? (s_axi_araddr == 4'h0) : rd_ctrl_q;
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Properties
  // ****************************************
  property p_pin_en; pin_select_wr_en == ($past(pin_select_wr_req) && !$past(pin_select_lock));
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin select enable wrong");
  property p_mod_en;
    module_disable_wr_en == ($past(module_disable_wr_req) && !$past(module_disable_lock));
  endproperty
  a_mod_en: assert property (p_mod_en) else $error("module disable enable wrong");
  property p_zero; $rose(s_axi_rvalid) && rd_ctrl_q |-> (s_axi_rdata & 32'hffff_cff0) == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("unused bits not zero");
  property p_ones; $rose(s_axi_rvalid) && rd_ctrl_q |-> s_axi_rdata[2:1] == 2'b11; endproperty
  a_ones: assert property (p_ones) else $error("bits 2..1 not one");
  property p_fld; $rose(s_axi_rvalid) && rd_ctrl_q |-> s_axi_rdata[3] == debug_port_enable
    && s_axi_rdata[13:12] == {pin_select_lock, module_disable_lock}; endproperty
  a_fld: assert property (p_fld) else $error("read fields differ from outputs");
  property p_tdo; $rose(s_axi_rvalid) && rd_ctrl_q |-> s_axi_rdata[0] == two_wire_output_use;
  endproperty
  a_tdo: assert property (p_tdo) else $error("two wire bit differs");
  property p_lock; $changed({pin_select_lock, module_disable_lock}) |-> $rose(s_axi_bvalid);
  endproperty
  a_lock: assert property (p_lock) else $error("lock moved without a write");
  property p_early; cnt_q < 6'd29 |-> !fetch_enable; endproperty
  a_early: assert property (p_early) else $error("fetch enabled too early");
  property p_late; cnt_q == 6'd29 |-> fetch_enable; endproperty
  a_late: assert property (p_late) else $error("fetch not enabled");
  property p_fuse; cnt_q == 6'd29 |-> debug_port_enable == cfg_word0_dbg_en; endproperty
  a_fuse: assert property (p_fuse) else $error("debug enable not from fuse");
endmodule

bind config_control config_control_checker config_control_checker_i
(
  .ref_clk, .rst_b, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_bvalid, .cfg_word0_dbg_en, .pin_select_wr_req,
  .module_disable_wr_req, .pin_select_wr_en, .module_disable_wr_en, .debug_port_enable,
  .two_wire_output_use, .pin_select_lock, .module_disable_lock, .fetch_enable
);
`default_nettype wire

// File: dv/config_control_tb.sv
// Self-checking bench for the configuration control block
`timescale 1ns/1ps
`default_nettype none
`include "config_control_map.vh"
module config_control_tb;
  logic        ref_clk, rst_b, cfg_word0_dbg_en, pin_select_wr_req, module_disable_wr_req;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        pin_select_wr_en, module_disable_wr_en, debug_port_enable, fetch_enable;
  logic        two_wire_output_use, pin_select_lock, module_disable_lock;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lk;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          n_mismatch, checks_done, i;

  config_control config_control_i
  (
    .ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cfg_word0_dbg_en, .pin_select_wr_req,
    .module_disable_wr_req, .pin_select_wr_en, .module_disable_wr_en, .debug_port_enable,
    .two_wire_output_use, .pin_select_lock, .module_disable_lock, .fetch_enable
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together, each dropped once its own ready is seen
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    logic aw, w;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge ref_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Both guarded groups asked at once; enables stand a single cycle
  task automatic prot(input logic [1:0] e);
    pin_select_wr_req <= 1'b1;
    module_disable_wr_req <= 1'b1;
    @(posedge ref_clk);
    pin_select_wr_req <= 1'b0;
    module_disable_wr_req <= 1'b0;
    @(posedge ref_clk);
    cmp("wr_en", e, {pin_select_wr_en, module_disable_wr_en});
  endtask

  task automatic unlock();
    wr(`CFG_UNLOCK_OFFSET, `CFG_KEY1, 2'b00);
    wr(`CFG_UNLOCK_OFFSET, `CFG_KEY2, 2'b00);
  endtask

  function automatic logic [33:0] ctl(input logic [31:0] v, input logic [1:0] l);
    return {2'b00, 18'h0, l, 8'h0, v[3], 2'b11, v[0]};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Clock, scoreboard, watchdog
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Oldest note is matched against each accepted response
  always @(posedge ref_clk)
  begin
    if (s_axi_rvalid && s_axi_rready) cmp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", bq.pop_front(), s_axi_bresp);
  end

  // Sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {pin_select_wr_req, module_disable_wr_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    lk = 2'b00;
    i = $urandom(91);
    cfg_word0_dbg_en = 1'($urandom);
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    i = 0;
    while (!fetch_enable)
    begin
      @(posedge ref_clk);
      i++;
    end
    cmp("boot", 1'b1, i > 28 && i < 40);
    rd(`CFG_CTRL_OFFSET, {30'h0, cfg_word0_dbg_en, 3'b111});
    rd(`CFG_STATUS_OFFSET, 34'h0_0000_0001);
    prot(2'b11);
    for (i = 0; i < 8; i++)
    begin
      if (i == 4)
      begin
        unlock();
        wr(`CFG_CTRL_OFFSET, 32'h0000_3009, 2'b00);
        lk = 2'b11;
        rd(`CFG_CTRL_OFFSET, 34'h0_0000_300f);
        prot(2'b00);
      end
      d = $urandom;
      wr(`CFG_CTRL_OFFSET, d, 2'b00);
      rd(`CFG_CTRL_OFFSET, ctl(d, lk));
    end
    unlock();
    rd(`CFG_UNLOCK_OFFSET, 34'h0_0000_0001);
    wr(`CFG_CTRL_OFFSET, 32'h0, 2'b00);
    lk = 2'b00;
    rd(`CFG_CTRL_OFFSET, 34'h0_0000_0006);
    cmp("ctl", {2'b00, lk},
        {debug_port_enable, two_wire_output_use, pin_select_lock, module_disable_lock});
    prot(2'b11);
    wr(4'hc, 32'hffff_ffff, 2'b10);
    rd(4'hc, {2'b10, 32'h0});
    rd(`CFG_CTRL_OFFSET, 34'h0_0000_0006);
    repeat (4) @(posedge ref_clk);
    end_sim();
  end
endmodule
`default_nettype wire
